// ==== src/bus_chain_pick.sv ====
// Picks one requester among the devices sharing a hardware level.
// Assumes index 0 is the device nearest the processor on the bus.
`timescale 1ns/1ns
module bus_chain_pick #(
  parameter int unsigned DEVS = pi_pkg::DEVS  // Devices on the chain
) (
  input  wire logic [DEVS-1:0] req,   // Raw device requests
  output logic      [DEVS-1:0] pick   // One-hot winner, zero if none
);

  // Nearest device wins: keep only the lowest set bit
  always_comb begin
    logic taken;
    taken = 1'b0;
    pick  = '0;
    for (int i = 0; i < DEVS; i++) begin
      if (req[i] && !taken) begin
        pick[i] = 1'b1;
        taken   = 1'b1;
      end
    end
  end

endmodule : bus_chain_pick

// ==== src/pi_pkg.sv ====
// Package for the eight-level priority interrupt unit: bus offsets, field
// positions, operation codes, entry addresses and reset values.
// Assumes an 18-bit accumulator whose bit 00 is its most significant bit.
package pi_pkg;

  // Sizes
  localparam int unsigned LEVELS    = 8;   // Priority levels
  localparam int unsigned HW_LEVELS = 4;   // Levels raised by bus devices
  localparam int unsigned DEVS      = 8;   // Devices sharing one hardware level
  localparam int unsigned AC_W      = 18;  // Accumulator width
  localparam int unsigned ADDR_W    = 15;  // Entry address width
  localparam int unsigned APB_AW    = 8;   // Decoded address bits

  // Register byte offsets
  localparam logic [7:0] OFF_ACCUM  = 8'h00;  // Accumulator image, read/write
  localparam logic [7:0] OFF_IOT    = 8'h04;  // Operation code, write executes
  localparam logic [7:0] OFF_RESULT = 8'h08;  // Status word from last status read
  localparam logic [7:0] OFF_STATE  = 8'h0c;  // Live state, read only

  // Live state word fields
  localparam int unsigned ST_PL_LSB  = 0;   // Active levels, 8 bits
  localparam int unsigned ST_RR_LSB  = 8;   // Requests, 8 bits
  localparam int unsigned ST_ENABLE  = 16;  // Unit enabled
  localparam int unsigned ST_SKIP    = 17;  // Last skip test result
  localparam int unsigned ST_HOLD    = 18;  // Grant hold-off running

  // Accumulator bit positions (bit 00 is index 17)
  localparam int unsigned ACB_ENABLE  = 17;  // Bit 00: enable
  localparam int unsigned ACB_REQ_TOP = 15;  // Bits 02-09: request level l at 15-l
  localparam int unsigned ACB_PL_TOP  = 7;   // Bits 10-17: level l at 7-l

  // Operation codes (octal 703304, 703344, 707742, 705501, 705504, 705512)
  localparam logic [17:0] OP_LEVEL_RELEASE   = 18'h386c4;
  localparam logic [17:0] OP_RELEASE_RESTORE = 18'h386e4;
  localparam logic [17:0] OP_STATUS_RESTORE  = 18'h38fe2;
  localparam logic [17:0] OP_SKIP_TEST       = 18'h38b41;
  localparam logic [17:0] OP_SELECT_ACTIVITY = 18'h38b44;
  localparam logic [17:0] OP_STATUS_READ     = 18'h38b4a;

  // Software levels enter at octal 40 upward
  localparam logic [14:0] SW_ENTRY_BASE = 15'h0020;

  // Level numbers with a fixed meaning
  localparam logic [2:0] LVL_PROG_INT = 3'h3;  // Ordinary program interrupt
  localparam logic [2:0] LVL_CALL     = 3'h4;  // Call trap

  // Instructions that must complete before grants resume after restore
  localparam logic [1:0] HOLD_INSTRS = 2'h2;

  // Reset values
  localparam logic [7:0]  RST_LEVELS = 8'h00;
  localparam logic [17:0] RST_WORD   = 18'h00000;

endpackage : pi_pkg

// ==== src/priority_interrupt_unit.sv ====
// Eight-level priority interrupt unit with APB access for operations.
// Assumes the processor pulses instr_done as each instruction completes
// and that devices drive io_addr while their dev_ack bit is high.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
module priority_interrupt_unit #(
  parameter int unsigned DEVS   = pi_pkg::DEVS,    // Devices per hardware level
  parameter int unsigned ADDR_W = pi_pkg::ADDR_W   // Entry address width
) (
  input  wire logic                           pclk,            // Clock, 10 MHz
  input  wire logic                           presetn,         // Async reset, low
  input  wire logic                           ce,              // Clock enable
  input  wire logic [pi_pkg::APB_AW-1:0]      paddr,           // APB address
  input  wire logic                           psel,            // APB select
  input  wire logic                           penable,         // APB enable
  input  wire logic                           pwrite,          // APB direction
  input  wire logic [31:0]                    pwdata,          // APB write data
  output logic      [31:0]                    prdata,          // APB read data
  output logic                                pready,          // APB ready
  output logic                                pslverr,         // APB error
  input  wire logic [pi_pkg::HW_LEVELS*DEVS-1:0] dev_req,      // Device requests
  output logic      [pi_pkg::HW_LEVELS*DEVS-1:0] dev_ack,      // Granted device
  input  wire logic [ADDR_W-1:0]              io_addr,         // Granted entry addr
  input  wire logic                           instr_done,      // Instruction ended
  input  wire logic                           prog_int_taken,  // Program int taken
  input  wire logic                           call_trap,       // Call executed
  output logic                                break_req,       // Stop after instr
  output logic                                grant,           // Grant pulse
  output logic      [2:0]                     grant_level,     // Granted level
  output logic      [ADDR_W-1:0]              mem_out_addr,    // Entry address
  output logic                                pc_hold,         // Keep program count
  output logic                                restore_arm,     // Arm mode restore
  output logic                                prog_int_req,    // To program int
  output logic                                skip_next        // Skip test result
);

  localparam int unsigned NL = pi_pkg::LEVELS;
  localparam int unsigned NH = pi_pkg::HW_LEVELS;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic                     enable;        // Unit enabled
  logic [NL-1:0]            rr;            // level_request_reg
  logic [NL-1:0]            pl;            // active_level_reg
  logic [pi_pkg::AC_W-1:0]  accumulator;   // Accumulator image
  logic [pi_pkg::AC_W-1:0]  status_word;   // Last status read
  logic [1:0]               hold_cnt;      // Instructions left before grants
  logic                     data_ok;       // Read data loaded for this transfer

  // Decoded operations
  logic                     wr_fire;       // Write completes this edge
  logic [17:0]              iot;           // Written operation code
  logic                     level_release_op;
  logic                     release_and_restore_op;
  logic                     status_restore_op;
  logic                     skip_test_op;
  logic                     select_activity_op;
  logic                     status_read_op;

  // Scan results
  logic [NL-1:0]            accept;        // Requests not blocked
  logic [NL-1:0]            free;          // Level and all higher inactive
  logic [2:0]               pick_level;    // Highest acceptable level
  logic [2:0]               top_level;     // Highest active level
  logic                     top_valid;     // Any level active
  logic                     grant_now;     // Grant taken this edge
  logic                     spi_hit;       // Skip condition holds
  logic [NL-1:0]            raise_ok;      // Accepted raises
  logic [NH-1:0]            hw_any;        // Any device on hardware level
  logic [NH*DEVS-1:0]       chain_pick;    // Per-level winners
  logic [NL-1:0]            next_rr;       // Next requests
  logic [NL-1:0]            next_pl;       // Next active levels
  logic [pi_pkg::AC_W-1:0]  live_status;   // Status word as it stands

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: no wait state, read data loads during the setup phase
  assign pready  = penable & data_ok & ce;
  assign wr_fire = psel & penable & pwrite & pready;
  assign pslverr = psel & penable & (paddr != pi_pkg::OFF_ACCUM) &
                   (paddr != pi_pkg::OFF_IOT) & (paddr != pi_pkg::OFF_RESULT) &
                   (paddr != pi_pkg::OFF_STATE);
  assign iot     = pwdata[17:0];

  // Operation strobes, one per completed write to the code register
  always_comb begin
    logic hit;
    hit                    = wr_fire && (paddr == pi_pkg::OFF_IOT);
    level_release_op       = hit && (iot == pi_pkg::OP_LEVEL_RELEASE);
    release_and_restore_op = hit && (iot == pi_pkg::OP_RELEASE_RESTORE);
    status_restore_op      = hit && (iot == pi_pkg::OP_STATUS_RESTORE);
    skip_test_op           = hit && (iot == pi_pkg::OP_SKIP_TEST);
    select_activity_op     = hit && (iot == pi_pkg::OP_SELECT_ACTIVITY);
    status_read_op         = hit && (iot == pi_pkg::OP_STATUS_READ);
  end

  // Read data is loaded once per transfer and then held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ok <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      if (!psel || pready) begin
        data_ok <= 1'b0;                      // Transfer over or idle
      end else if (!data_ok) begin
        data_ok <= 1'b1;
        case (paddr)
          pi_pkg::OFF_ACCUM:  prdata <= {14'h0000, accumulator};
          pi_pkg::OFF_RESULT: prdata <= {14'h0000, status_word};
          pi_pkg::OFF_STATE:  prdata <= {13'h0000, (hold_cnt != 2'h0), skip_next,
                                         enable, rr, pl};
          default:            prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Accumulator image written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accumulator <= pi_pkg::RST_WORD;
    end else if (ce && wr_fire && (paddr == pi_pkg::OFF_ACCUM)) begin
      accumulator <= pwdata[17:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device chains, one per hardware level
  for (genvar g = 0; g < NH; g++) begin : g_chain
    bus_chain_pick #(.DEVS(DEVS)) u_pick (
      .req  (dev_req[g*DEVS +: DEVS]),
      .pick (chain_pick[g*DEVS +: DEVS])
    );
    assign hw_any[g] = |dev_req[g*DEVS +: DEVS];
    // Acknowledge only the winning device of the level being granted
    assign dev_ack[g*DEVS +: DEVS] =
      (grant_now && (pick_level == 3'(g))) ? chain_pick[g*DEVS +: DEVS] : '0;
  end

  // Disabled unit passes device requests to the program interrupt
  assign prog_int_req = !enable && (|hw_any);

  ////////////////////////////////////////////////////////////////////////////
  // Scanner: a level is acceptable only if no equal or higher level is active
  always_comb begin
    logic blocked;
    logic found;
    logic tfound;
    blocked    = 1'b0;
    found      = 1'b0;
    tfound     = 1'b0;
    accept     = '0;
    free       = '0;
    pick_level = 3'h0;
    top_level  = 3'h0;
    for (int i = 0; i < NL; i++) begin
      blocked   = blocked | pl[i];
      accept[i] = rr[i] & ~blocked;
      free[i]   = ~blocked;
      if (accept[i] && !found) begin
        pick_level = 3'(i);
        found      = 1'b1;
      end
      if (pl[i] && !tfound) begin
        top_level = 3'(i);
        tfound    = 1'b1;
      end
    end
    top_valid = tfound;
  end

  assign break_req = enable & (|accept);
  // The restore op's own edge takes no grant either, so the hold starts clean
  assign grant_now = ce & instr_done & break_req & (hold_cnt == 2'h0) &
                     ~release_and_restore_op;

  // Skip test and raise acceptance from the accumulator
  always_comb begin
    spi_hit  = accumulator[pi_pkg::ACB_ENABLE] & enable;
    raise_ok = '0;
    for (int l = 0; l < NL; l++) begin
      spi_hit     = spi_hit | (accumulator[pi_pkg::ACB_PL_TOP - l] & free[l]);
      raise_ok[l] = accumulator[pi_pkg::ACB_PL_TOP - l] & free[l];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request register: sets win over the clear from release-and-restore
  always_comb begin
    logic [NL-1:0] set;
    logic [NL-1:0] clr;
    set = '0;
    clr = '0;
    for (int l = 0; l < NL; l++) begin
      if (l < NH) begin
        set[l] = enable & hw_any[l];
      end
      if (select_activity_op) begin
        set[l] = set[l] | accumulator[pi_pkg::ACB_REQ_TOP - l];
      end
    end
    if (release_and_restore_op && top_valid) begin
      clr[top_level] = 1'b1;
    end
    next_rr = (rr & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr <= pi_pkg::RST_LEVELS;
    end else if (ce) begin
      rr <= next_rr;
    end
  end

  // Active-level register: grants, raises, traps set; releases clear
  always_comb begin
    logic [NL-1:0] set;
    logic [NL-1:0] clr;
    set = '0;
    clr = '0;
    if (grant_now) begin
      set[pick_level] = 1'b1;
    end
    if (select_activity_op) begin
      set = set | raise_ok;
    end
    if (call_trap && !(|pl[NH-1:0])) begin
      set[pi_pkg::LVL_CALL] = 1'b1;
    end
    if (prog_int_taken) begin
      set[pi_pkg::LVL_PROG_INT] = 1'b1;
    end
    if ((level_release_op || release_and_restore_op) && top_valid) begin
      clr[top_level] = 1'b1;
    end
    next_pl = (pl & ~clr) | set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pl <= pi_pkg::RST_LEVELS;
    end else if (ce) begin
      pl <= next_pl;
    end
  end

  // Enable flag follows bit 00 of each select-activity word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= 1'b0;
    end else if (ce && select_activity_op) begin
      enable <= accumulator[pi_pkg::ACB_ENABLE];
    end
  end

  // Hold-off: the restore op itself and the instruction after it finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 2'h0;
    end else if (ce) begin
      if (release_and_restore_op) begin
        hold_cnt <= pi_pkg::HOLD_INSTRS;
      end else if (instr_done && (hold_cnt != 2'h0)) begin
        hold_cnt <= hold_cnt - 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant outputs toward the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant        <= 1'b0;
      pc_hold      <= 1'b0;
      grant_level  <= 3'h0;
      mem_out_addr <= '0;
    end else if (ce) begin
      grant   <= grant_now;
      pc_hold <= grant_now;
      if (grant_now) begin
        grant_level <= pick_level;
        if (pick_level < 3'(NH)) begin
          mem_out_addr <= io_addr;
        end else begin
          mem_out_addr <= ADDR_W'(pi_pkg::SW_ENTRY_BASE) +
                          ADDR_W'(pick_level - 3'(NH));
        end
      end
    end
  end

  // Restore arming, skip result and status capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restore_arm <= 1'b0;
      skip_next   <= 1'b0;
      status_word <= pi_pkg::RST_WORD;
    end else if (ce) begin
      restore_arm <= release_and_restore_op | status_restore_op;
      if (skip_test_op) begin
        skip_next <= spi_hit;
      end
      if (status_read_op) begin
        status_word <= live_status;
      end
    end
  end

  // Status layout: enable in bit 00, requests in 02-09, levels in 10-17
  always_comb begin
    live_status = '0;
    live_status[pi_pkg::ACB_ENABLE] = enable;
    for (int l = 0; l < NL; l++) begin
      live_status[pi_pkg::ACB_REQ_TOP - l] = rr[l];
      live_status[pi_pkg::ACB_PL_TOP - l]  = pl[l];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_grant_sets_level: assert property (grant |-> pl[grant_level])
    else $error("granted level not active");
  a_grant_when_enabled: assert property (grant |-> $past(enable))
    else $error("grant while disabled");
  a_highest_first: assert property (grant |->
    (($past(accept) & ((8'h01 << grant_level) - 8'h01)) == 8'h00))
    else $error("lower level granted first");
  a_blocked_refused: assert property (grant |->
    (($past(pl) & ((8'h02 << grant_level) - 8'h01)) == 8'h00))
    else $error("grant at or below active level");
  a_break_grants: assert property (
    ce && instr_done && break_req && hold_cnt == 2'h0 && !release_and_restore_op |=> grant)
    else $error("break request not granted");
  a_restore_holds: assert property (
    ce && release_and_restore_op |=> hold_cnt == 2'h2 && !grant)
    else $error("restore hold not started");
  a_hold_blocks: assert property (hold_cnt != 2'h0 |=> !grant)
    else $error("grant during hold");
  a_release_lowers: assert property (
    ce && level_release_op && top_valid && !instr_done && !call_trap
    && !prog_int_taken |=> $countones(pl) == $countones($past(pl)) - 1)
    else $error("release did not clear one level");
  a_trap_level4: assert property (
    ce && call_trap && pl[3:0] == 4'h0 |=> pl[4])
    else $error("call trap missed level 4");
  a_prog_int_l3: assert property (ce && prog_int_taken |=> pl[3])
    else $error("program interrupt missed level 3");
  a_disabled_route: assert property (
    !enable && |dev_req |-> prog_int_req && !break_req)
    else $error("disabled request not routed");

  c_hw_grant: cover property (grant && grant_level < 3'h4);
  c_sw_grant: cover property (grant && grant_level >= 3'h4);
  c_preempt: cover property (grant && $past(pl) != 8'h00);
  c_restore: cover property (release_and_restore_op ##1 hold_cnt == 2'h2);

endmodule : priority_interrupt_unit

// ==== tb/priority_interrupt_unit_tb.sv ====
// Testbench: APB operations and processor link checks.
// Assumes proc_model supplies instruction pulses and entry addresses.
`timescale 1ns/1ns
module priority_interrupt_unit_tb;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, dev_req, dev_ack, q;
  logic [14:0] io_addr, mem_out_addr, pc;
  logic [2:0]  grant_level;
  logic        instr_done, prog_int_taken, call_trap, break_req, grant;
  logic        pc_hold, restore_arm, prog_int_req, skip_next;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  ////////////////////////////////////////////////////////////////////
  priority_interrupt_unit dut (.pclk, .presetn, .ce, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .dev_req, .dev_ack, .io_addr,
    .instr_done, .prog_int_taken, .call_trap, .break_req, .grant, .grant_level,
    .mem_out_addr, .pc_hold, .restore_arm, .prog_int_req, .skip_next);
  proc_model #(.GAP(6)) host (.pclk, .presetn, .dev_ack, .pc_hold, .instr_done,
    .io_addr, .pc);
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  // Ends the run when a bounded wait ran out
  task automatic hang(input logic ok);
    if (!ok) begin
      n_mismatch++;
      give_verdict();
    end
  endtask : hang
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    hang(pready === 1'b1);
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic op(input logic [17:0] acc, input logic [17:0] code);
    apb(1'b1, pi_pkg::OFF_ACCUM, 32'(acc));
    apb(1'b1, pi_pkg::OFF_IOT, 32'(code));
  endtask : op
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd
  task automatic wait_grant(input logic [2:0] lv, input logic [14:0] a);
    int n;
    logic [14:0] p;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (grant !== 1'b1 && n < 300);
    hang(grant === 1'b1);
    check({pc_hold, grant_level, mem_out_addr}, {13'h0, 1'b1, lv, a});
    // Program count must survive the channel instruction
    p = pc;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (instr_done !== 1'b1 && n < 20);
    hang(instr_done === 1'b1);
    @(negedge pclk);
    check(pc, p);
  endtask : wait_grant
  task automatic quiet(input int c);
    int g;
    g = 0;
    repeat (c) begin
      @(negedge pclk);
      if (grant !== 1'b0) g++;
    end
    check(g, 0);
  endtask : quiet
  function automatic logic [17:0] b(input int p);
    return 18'h1 << p;
  endfunction : b
  // Live state word with the unit enabled and no hold-off
  function automatic logic [31:0] sw(input logic [7:0] pl, rr, input logic sk);
    return (32'(pl) << pi_pkg::ST_PL_LSB) | (32'(rr) << pi_pkg::ST_RR_LSB)
         | (32'h1 << pi_pkg::ST_ENABLE) | (32'(sk) << pi_pkg::ST_SKIP);
  endfunction : sw
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////
  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {dev_req, prog_int_taken, call_trap} = '0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    dev_req <= 32'h0028_0000;  // Level 2, devices 3 and 5
    @(negedge pclk);
    check(prog_int_req, 1'b1);
    rd(pi_pkg::OFF_STATE, 32'h0);
    $display("test reset done");
    op(b(17), pi_pkg::OP_SELECT_ACTIVITY);
    wait_grant(3'h2, 15'h0053);
    @(posedge pclk);
    dev_req <= 32'h0;
    op(b(17) | b(10), pi_pkg::OP_SELECT_ACTIVITY);
    quiet(20);
    rd(pi_pkg::OFF_STATE, sw(8'h04, 8'h24, 1'b0));
    op(b(17) | b(1), pi_pkg::OP_SELECT_ACTIVITY);
    op(b(17) | b(6), pi_pkg::OP_SELECT_ACTIVITY);
    quiet(10);
    rd(pi_pkg::OFF_STATE, sw(8'h06, 8'h24, 1'b0));
    $display("test raise done");
    op(b(6), pi_pkg::OP_SKIP_TEST);
    check(skip_next, 1'b0);
    op(b(7), pi_pkg::OP_SKIP_TEST);
    check(skip_next, 1'b1);
    op(18'h0, pi_pkg::OP_LEVEL_RELEASE);
    check(restore_arm, 1'b0);
    rd(pi_pkg::OFF_STATE, sw(8'h04, 8'h24, 1'b1));
    op(18'h0, pi_pkg::OP_RELEASE_RESTORE);
    check(restore_arm, 1'b1);
    quiet(5);
    wait_grant(3'h5, pi_pkg::SW_ENTRY_BASE + 15'h1);
    rd(pi_pkg::OFF_STATE, sw(8'h20, 8'h20, 1'b1));
    $display("test release done");
    op(18'h0, pi_pkg::OP_STATUS_READ);
    rd(pi_pkg::OFF_RESULT, 32'h0002_0404);
    @(posedge pclk);
    prog_int_taken <= 1'b1;
    @(posedge pclk);
    prog_int_taken <= 1'b0;
    rd(pi_pkg::OFF_STATE, sw(8'h28, 8'h20, 1'b1));
    op(18'h0, pi_pkg::OP_STATUS_RESTORE);
    check(restore_arm, 1'b1);
    rd(pi_pkg::OFF_STATE, sw(8'h28, 8'h20, 1'b1));
    op(b(0), pi_pkg::OP_SKIP_TEST);
    check(skip_next, 1'b0);
    op(b(17), pi_pkg::OP_SKIP_TEST);
    check(skip_next, 1'b1);
    // Call trap refused while hardware level 3 is active, taken after release
    @(posedge pclk);
    call_trap <= 1'b1;
    @(posedge pclk);
    call_trap <= 1'b0;
    rd(pi_pkg::OFF_STATE, sw(8'h28, 8'h20, 1'b1));
    op(18'h0, pi_pkg::OP_LEVEL_RELEASE);
    @(posedge pclk);
    call_trap <= 1'b1;
    @(posedge pclk);
    call_trap <= 1'b0;
    rd(pi_pkg::OFF_STATE, sw(8'h30, 8'h20, 1'b1));
    $display("test restore done");
    // A program interrupt pulse while the clock enable is low is lost
    @(posedge pclk);
    ce             <= 1'b0;
    prog_int_taken <= 1'b1;
    @(posedge pclk);
    prog_int_taken <= 1'b0;
    @(posedge pclk);
    ce             <= 1'b1;
    // Disable and post a maintenance request on level 2 in one word
    op(b(13), pi_pkg::OP_SELECT_ACTIVITY);
    rd(pi_pkg::OFF_STATE, 32'h0002_2430);
    @(posedge pclk);
    dev_req <= 32'h1;
    @(negedge pclk);
    check({prog_int_req, break_req}, 2'b10);
    apb(1'b0, 8'h40, 32'h0);
    check(e, 1'b1);
    check(q, 32'h0);
    $display("test disable done");
    give_verdict();
  end
endmodule : priority_interrupt_unit_tb

// ==== tb/proc_model.sv ====
// Processor and bus device model: instruction pulses, entry addresses.
// Assumes the unit samples io_addr while one dev_ack bit is high.
`timescale 1ns/1ns
module proc_model #(
  parameter int unsigned GAP = 6  // Cycles per instruction, 1 is prompt
) (
  input  wire logic        pclk,        // Clock
  input  wire logic        presetn,     // Reset, active low
  input  wire logic [31:0] dev_ack,     // Granted device
  input  wire logic        pc_hold,     // Channel instruction follows
  output logic             instr_done,  // Instruction end pulse
  output logic      [14:0] io_addr,     // Entry address from acked device
  output logic      [14:0] pc           // Program counter image
);
  int unsigned cnt;   // Cycle within instruction
  logic        tog;   // Idle bus pattern
  logic        chan;  // Instruction in flight is a channel fetch
  ////////////////////////////////////////////////////////////////////
  // Instruction timer and idle pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 0;
      instr_done <= 1'b0;
      tog        <= 1'b0;
      chan       <= 1'b0;
      pc         <= 15'h0000;
    end else begin
      tog        <= ~tog;
      // Channel instruction completes without advancing the count
      if (pc_hold) begin
        chan <= 1'b1;
      end else if (instr_done) begin
        chan <= 1'b0;
      end
      if (instr_done && !chan) begin
        pc <= pc + 15'h0001;
      end
      instr_done <= (cnt == GAP - 1);
      cnt        <= (cnt == GAP - 1) ? 0 : cnt + 1;
    end
  end
  // Acked device drives its own address; released bus toggles
  always_comb begin
    io_addr = {15{tog}};
    for (int i = 0; i < 32; i++) begin
      if (dev_ack[i]) io_addr = 15'h0040 + 15'(i);
    end
  end
endmodule : proc_model
